// >>> dcf_fifo_block.sv
// dual port memory block with embedded gray-pointer fifo controller
`timescale 1ns/1ps
// Notes on behaviour
// - pipe off: read location taken at read edge, data follows next cycle
// - pipe on: read data registered twice, data after second read edge
// - write edge with strobe high stores write data at write location
// - each block holds its own fifo controller, one write and one read port
// - port aspect ratio selectable from deep narrow to shallow wide
// - fifo mode: one word queued per write edge while strobe high
// - fifo mode: one word removed and driven per read edge while strobe high
// - full, empty and programmable almost flags, all glitch free registers
// - full flag on write side blocks writes to prevent overrun
// - empty flag on read side blocks reads to prevent underflow
// - pointers are gray counters so crossings change one bit at a time
// - fifo depth follows data width and number of combined blocks
// - write side runs on write clock edges, read side on read clock edges
// - reset returns fifo to empty, clearing both pointers
// - each port clock may act on rising or falling edge independently
// - port widths 1, 2, 4, 9, 18 or 36 bits
// - little-endian mapping when port widths differ
module dcf_fifo_block
    import dcf_pkg::*;
#(
    parameter int WR_W   = DCF_WIDTH_DEF,
    parameter int RD_W   = DCF_WIDTH_DEF,
    parameter int BLOCKS = DCF_BLOCKS_DEF,
    localparam int WR_DEPTH = dcf_depth(WR_W, BLOCKS),
    localparam int RD_DEPTH = dcf_depth(RD_W, BLOCKS),
    localparam int WA_W     = dcf_addr_w(WR_DEPTH),
    localparam int RA_W     = dcf_addr_w(RD_DEPTH),
    localparam int PTR_W    = WA_W + 1
)(
    input  wire logic             i_clock,
    input  wire logic             i_sys_rst,
    input  wire logic             i_write_clock,
    input  wire logic             i_read_clock,
    input  wire logic             i_wclk_falling,
    input  wire logic             i_rclk_falling,
    input  wire logic             i_pipe_on,
    input  wire logic             i_fifo_mode,
    input  wire logic             i_fifo_clear,
    input  wire logic             i_write_strobe,
    input  wire logic [WA_W-1:0]  i_write_location,
    input  wire logic [WR_W-1:0]  i_write_in_bus,
    input  wire logic             i_read_strobe,
    input  wire logic [RA_W-1:0]  i_read_location,
    input  wire logic [PTR_W-1:0] i_almost_topped_level,
    input  wire logic [PTR_W-1:0] i_almost_drained_level,
    output logic      [RD_W-1:0]  o_read_out_bus,
    output logic                  o_full,
    output logic                  o_empty,
    output logic                  o_almost_topped_flag,
    output logic                  o_almost_drained_flag
);
    localparam logic [PTR_W-1:0] PTR_RST = PTR_W'(DCF_PTR_RST);
    localparam logic [RD_W-1:0]  OUT_RST = RD_W'(DCF_OUT_RST);

    function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b[PTR_W-1] = g[PTR_W-1];
        for (int i = PTR_W - 2; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // port clocks arrive as pins: two flops, then a third for edge detection
    logic wclk_meta;
    logic wclk_sync;
    logic wclk_prev;
    logic rclk_meta;
    logic rclk_sync;
    logic rclk_prev;

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            wclk_meta <= 1'b0;
            wclk_sync <= 1'b0;
            wclk_prev <= 1'b0;
            rclk_meta <= 1'b0;
            rclk_sync <= 1'b0;
            rclk_prev <= 1'b0;
        end
        else
        begin
            wclk_meta <= i_write_clock;
            wclk_sync <= wclk_meta;
            wclk_prev <= wclk_sync;
            rclk_meta <= i_read_clock;
            rclk_sync <= rclk_meta;
            rclk_prev <= rclk_sync;
        end
    end

    // one-cycle enables on the selected active edge of each port clock
    logic wr_edge;
    logic rd_edge;
    assign wr_edge = i_wclk_falling ? (wclk_prev & ~wclk_sync)
                                    : (~wclk_prev & wclk_sync);
    assign rd_edge = i_rclk_falling ? (rclk_prev & ~rclk_sync)
                                    : (~rclk_prev & rclk_sync);

    // pointers, their gray images and the far-side copies
    logic [PTR_W-1:0] wbin;
    logic [PTR_W-1:0] wgray;
    logic [PTR_W-1:0] rbin;
    logic [PTR_W-1:0] rgray;
    logic [PTR_W-1:0] wgray_meta;
    logic [PTR_W-1:0] wgray_sync;
    logic [PTR_W-1:0] rgray_meta;
    logic [PTR_W-1:0] rgray_sync;
    logic [PTR_W-1:0] next_wbin;
    logic [PTR_W-1:0] next_rbin;
    logic [PTR_W-1:0] next_wgray;
    logic [PTR_W-1:0] next_rgray;
    logic             wr_go;
    logic             rd_go;

    // refused accesses never move a pointer
    assign wr_go = i_fifo_mode & wr_edge & i_write_strobe & ~o_full;
    assign rd_go = i_fifo_mode & rd_edge & i_read_strobe & ~o_empty;
    assign next_wbin  = wbin + PTR_W'(wr_go);
    assign next_rbin  = rbin + PTR_W'(rd_go);
    assign next_wgray = bin2gray(next_wbin);
    assign next_rgray = bin2gray(next_rbin);

    // only gray values cross, so a sampled pointer is off by at most one step
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst || i_fifo_clear)
        begin
            wgray_meta <= PTR_RST;
            wgray_sync <= PTR_RST;
            rgray_meta <= PTR_RST;
            rgray_sync <= PTR_RST;
        end
        else
        begin
            wgray_meta <= wgray;
            wgray_sync <= wgray_meta;
            rgray_meta <= rgray;
            rgray_sync <= rgray_meta;
        end
    end

    // write side: pointer and write-clock flags move only on write edges
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst || i_fifo_clear)
        begin
            wbin                 <= PTR_RST;
            wgray                <= PTR_RST;
            o_full               <= 1'b0;
            o_almost_topped_flag <= 1'b0;
        end
        else if (wr_edge)
        begin
            wbin   <= next_wbin;
            wgray  <= next_wgray;
            // full when the write pointer laps the read pointer by one depth
            o_full <= (next_wgray == {~rgray_sync[PTR_W-1:PTR_W-2],
                                      rgray_sync[PTR_W-3:0]});
            o_almost_topped_flag <=
                (next_wbin - gray2bin(rgray_sync)) >= i_almost_topped_level;
        end
    end

    // read side: pointer and read-clock flags move only on read edges
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst || i_fifo_clear)
        begin
            rbin                  <= PTR_RST;
            rgray                 <= PTR_RST;
            o_empty               <= 1'b1;
            o_almost_drained_flag <= 1'b1;
        end
        else if (rd_edge)
        begin
            rbin    <= next_rbin;
            rgray   <= next_rgray;
            o_empty <= (next_rgray == wgray_sync);
            o_almost_drained_flag <=
                (gray2bin(wgray_sync) - next_rbin) <= i_almost_drained_level;
        end
    end

    // storage ports: pointers in fifo mode, user locations in ram mode
    dcf_mem_if #(.WR_W(WR_W), .RD_W(RD_W), .WA_W(WA_W), .RA_W(RA_W)) mem ();

    logic rd_take;
    assign rd_take     = i_fifo_mode ? rd_go : (rd_edge & i_read_strobe);
    assign mem.wr_en   = i_fifo_mode ? wr_go : (wr_edge & i_write_strobe);
    assign mem.wr_addr = i_fifo_mode ? wbin[WA_W-1:0] : i_write_location;
    assign mem.wr_data = i_write_in_bus;
    // fifo mode assumes equal port widths so both pointers count the same words
    assign mem.rd_addr = i_fifo_mode ? RA_W'(rbin[WA_W-1:0]) : i_read_location;

    // embedded array; the controller above is dedicated to this one block
    dcf_store #(.WR_W(WR_W), .RD_W(RD_W), .BLOCKS(BLOCKS)) store_u (
        .i_clock (i_clock),
        .mem     (mem.store)
    );

    // read data path: one register without pipe, two with it
    logic [RD_W-1:0] pipe_stage;

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            pipe_stage     <= OUT_RST;
            o_read_out_bus <= OUT_RST;
        end
        else if (rd_edge)
        begin
            if (!i_pipe_on)
            begin
                if (rd_take)
                begin
                    o_read_out_bus <= mem.rd_data;
                end
            end
            else
            begin
                if (rd_take)
                begin
                    pipe_stage <= mem.rd_data;
                end
                o_read_out_bus <= pipe_stage;
            end
        end
    end
endmodule

// >>> dcf_pkg.sv
// shared constants and sizing functions for the dual clock memory fifo block
package dcf_pkg;

    // storage bits of one block for narrow (1,2,4) and byte-parity (9,18,36) widths
    localparam int DCF_BITS_NARROW = 4096;
    localparam int DCF_BITS_WIDE   = 4608;
    localparam int DCF_PARITY_UNIT = 9;
    localparam int DCF_MAX_W       = 36;
    localparam int DCF_WIDTH_DEF   = 36;
    localparam int DCF_BLOCKS_DEF  = 1;
    // two flip-flops for every crossing into i_clock logic
    localparam int DCF_SYNC_STAGES = 2;
    // pointer reset value and output reset value
    localparam int DCF_PTR_RST     = 0;
    localparam int DCF_OUT_RST     = 0;

    // words that fit in the chosen number of blocks at a given width
    function automatic int dcf_depth(input int width, input int blocks);
        int bits;
        bits = (width % DCF_PARITY_UNIT == 0) ? DCF_BITS_WIDE : DCF_BITS_NARROW;
        return (bits / width) * blocks;
    endfunction

    // address bits needed for a depth
    function automatic int dcf_addr_w(input int depth);
        int n;
        n = 1;
        while ((1 << n) < depth)
        begin
            n = n + 1;
        end
        return n;
    endfunction

endpackage

// >>> dcf_mem_if.sv
// bundle between the port controller and the storage array
`timescale 1ns/1ps
interface dcf_mem_if #(
    parameter int WR_W = 36,
    parameter int RD_W = 36,
    parameter int WA_W = 7,
    parameter int RA_W = 7
);
    logic            wr_en;
    logic [WA_W-1:0] wr_addr;
    logic [WR_W-1:0] wr_data;
    logic [RA_W-1:0] rd_addr;
    logic [RD_W-1:0] rd_data;

    modport ctrl  (output wr_en, output wr_addr, output wr_data, output rd_addr,
                   input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data, input rd_addr,
                   output rd_data);
endinterface

// >>> dcf_store.sv
// bit-addressed storage array with little-endian word mapping
`timescale 1ns/1ps
module dcf_store
    import dcf_pkg::*;
#(
    parameter int WR_W   = DCF_WIDTH_DEF,
    parameter int RD_W   = DCF_WIDTH_DEF,
    parameter int BLOCKS = DCF_BLOCKS_DEF
)(
    input  wire logic   i_clock,
    dcf_mem_if.store    mem
);
    localparam int TOT = dcf_depth(WR_W, BLOCKS) * WR_W;

    logic [TOT-1:0] bits;

    // word k occupies bits k*w .. k*w+w-1, so narrow words pack little-endian
    always_ff @(posedge i_clock)
    begin
        if (mem.wr_en)
        begin
            for (int i = 0; i < WR_W; i++)
            begin
                bits[int'(mem.wr_addr) * WR_W + i] <= mem.wr_data[i];
            end
        end
    end

    // combinational read; the controller owns the output registers
    always_comb
    begin
        int idx;
        idx = 0;
        mem.rd_data = '0;
        for (int i = 0; i < RD_W; i++)
        begin
            idx = int'(mem.rd_addr) * RD_W + i;
            if (idx < TOT)
            begin
                mem.rd_data[i] = bits[idx];
            end
        end
    end
endmodule

// >>> dcf_fifo_block_chk.sv
// port checks for the dual clock fifo block
`timescale 1ns/1ps
module dcf_fifo_block_chk
    import dcf_pkg::*;
#(
    parameter int RD_W  = DCF_WIDTH_DEF,
    parameter int PTR_W = 8
)(
    input wire logic             i_clock,
    input wire logic             i_sys_rst,
    input wire logic             i_write_clock,
    input wire logic             i_read_clock,
    input wire logic             i_pipe_on,
    input wire logic             i_fifo_mode,
    input wire logic             i_fifo_clear,
    input wire logic [PTR_W-1:0] i_almost_topped_level,
    input wire logic [RD_W-1:0]  o_read_out_bus,
    input wire logic             o_full,
    input wire logic             o_empty,
    input wire logic             o_almost_topped_flag,
    input wire logic             o_almost_drained_flag
);
    default clocking dc @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    // both port clocks and clear idle long enough for any edge pulse to land
    sequence s_quiet;
        ($stable(i_write_clock) && $stable(i_read_clock) && !i_fifo_clear) [*5];
    endsequence
    chk_reset_empty: assert property (
        $fell(i_sys_rst) |-> o_empty && !o_full && o_read_out_bus == '0) else $error("bad reset");
    chk_clear_empty: assert property (
        i_fifo_clear |=> o_empty && !o_full && o_almost_drained_flag) else $error("bad clear");
    // a full queue sits above any level below half the pointer range
    chk_full_topped: assert property (
        o_full && !i_almost_topped_level[PTR_W-1] |-> o_almost_topped_flag) else $error("no topped");
    chk_empty_drained: assert property (
        o_empty |-> o_almost_drained_flag) else $error("no drained");
    // flags move only on port edges, which lie several cycles apart
    chk_full_hold: assert property (
        $rose(o_full) |=> o_full [*4]) else $error("full glitch");
    chk_empty_hold: assert property (
        $fell(o_empty) |=> !o_empty [*4]) else $error("empty glitch");
    chk_refused_read: assert property (
        i_fifo_mode && !i_pipe_on && $past(o_empty) && o_empty |-> $stable(o_read_out_bus))
        else $error("refused read moved data");
    chk_quiet_hold: assert property (
        s_quiet |=> $stable(o_full) && $stable(o_empty) && $stable(o_read_out_bus))
        else $error("output moved without port edge");
endmodule
bind dcf_fifo_block dcf_fifo_block_chk #(.RD_W(RD_W), .PTR_W(PTR_W)) u_chk (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_write_clock(i_write_clock),
    .i_read_clock(i_read_clock), .i_pipe_on(i_pipe_on), .i_fifo_mode(i_fifo_mode),
    .i_fifo_clear(i_fifo_clear), .i_almost_topped_level(i_almost_topped_level),
    .o_read_out_bus(o_read_out_bus), .o_full(o_full), .o_empty(o_empty),
    .o_almost_topped_flag(o_almost_topped_flag), .o_almost_drained_flag(o_almost_drained_flag));

// >>> dcf_fabric_model.sv
// fabric user logic model driving the port clocks, strobes and data
`timescale 1ns/1ps
module dcf_fabric_model #(
    parameter int W  = 36,
    parameter int AW = 7
)(
    input  wire logic         i_clock,
    input  wire logic         i_wfall,
    input  wire logic         i_rfall,
    input  wire logic [W-1:0] i_rdata,
    output logic              o_wclk,
    output logic              o_rclk,
    output logic              o_wstb,
    output logic              o_rstb,
    output logic [AW-1:0]     o_waddr,
    output logic [AW-1:0]     o_raddr,
    output logic [W-1:0]      o_wdata
);
    // port clocks stand still between accesses
    initial {o_wclk, o_rclk, o_wstb, o_rstb, o_waddr, o_raddr, o_wdata} = '0;
    // park inactive, then one active edge with all qualifiers held five cycles
    task automatic wr(input logic [W-1:0] d, input logic en, input logic [AW-1:0] a);
        @(negedge i_clock);
        o_wclk = i_wfall;
        repeat (4) @(negedge i_clock);
        {o_wstb, o_wdata, o_waddr} = {en, d, a};
        o_wclk = ~i_wfall;
        repeat (5) @(negedge i_clock);
        {o_wstb, o_wdata, o_waddr} = {1'b0, ~d, ~a}; // released lines lose their value
    endtask
    // read access; data is taken once the synchroniser latency has passed
    task automatic rd(input logic [AW-1:0] a, output logic [W-1:0] q);
        @(negedge i_clock);
        o_rclk = i_rfall;
        repeat (4) @(negedge i_clock);
        {o_rstb, o_raddr} = {1'b1, a};
        o_rclk = ~i_rfall;
        repeat (5) @(negedge i_clock);
        q = i_rdata;
        {o_rstb, o_raddr} = {1'b0, ~a};
    endtask
endmodule

// >>> dcf_fifo_block_tb_top.sv
// self-checking bench for the dual clock fifo block
`timescale 1ns/1ps
module dcf_fifo_block_tb_top;
    import dcf_pkg::*;
    localparam int DEPTH = DCF_BITS_WIDE / 36;
`define DCF_CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wfall = 1'b0;
    logic        rfall = 1'b0;
    logic        pipe = 1'b0;
    logic        fmode = 1'b0;
    logic        clr = 1'b0;
    logic [35:0] q;
    logic [35:0] rdo;
    logic        full, empty, atop, adrn;
    wire         wclk, rclk, wstb, rstb;
    wire  [6:0]  wadr, radr;
    wire  [35:0] wdat;
    int          errors = 0;
    int          n_checks = 0;
    // almost levels: topped at 120 words, drained at 4 words
    dcf_fifo_block uut (.i_clock(clk), .i_sys_rst(rst), .i_write_clock(wclk),
        .i_read_clock(rclk), .i_wclk_falling(wfall), .i_rclk_falling(rfall), .i_pipe_on(pipe),
        .i_fifo_mode(fmode), .i_fifo_clear(clr), .i_write_strobe(wstb), .i_write_location(wadr),
        .i_write_in_bus(wdat), .i_read_strobe(rstb), .i_read_location(radr),
        .i_almost_topped_level(8'h78), .i_almost_drained_level(8'h04), .o_read_out_bus(rdo),
        .o_full(full), .o_empty(empty), .o_almost_topped_flag(atop), .o_almost_drained_flag(adrn));
    dcf_fabric_model m (.i_clock(clk), .i_wfall(wfall), .i_rfall(rfall), .i_rdata(rdo),
        .o_wclk(wclk), .o_rclk(rclk), .o_wstb(wstb), .o_rstb(rstb), .o_waddr(wadr),
        .o_raddr(radr), .o_wdata(wdat));
    always #4 clk = ~clk;
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ram writes incl. a strobe-low one, both edge senses, then pipelined reads
    task automatic t_ram;
        `DCF_CHK({empty, full, adrn, rdo}, {3'b101, 36'h0})
        m.wr(36'h123456789, 1'b1, 7'h05);
        m.wr(36'h0abcdef01, 1'b1, 7'h7f);
        m.wr(36'hfedcba987, 1'b0, 7'h05);
        m.rd(7'h05, q);
        `DCF_CHK(q, 36'h123456789)
        m.rd(7'h7f, q);
        `DCF_CHK(q, 36'h0abcdef01)
        @(negedge clk);
        {wfall, rfall} = 2'b11;
        m.wr(36'h5a5a5a5a5, 1'b1, 7'h03);
        m.rd(7'h03, q);
        `DCF_CHK(q, 36'h5a5a5a5a5)
        @(negedge clk);
        {wfall, rfall, pipe} = 3'b001;
        m.rd(7'h05, q);
        m.rd(7'h7f, q);
        `DCF_CHK(q, 36'h123456789)
        m.rd(7'h03, q);
        `DCF_CHK(q, 36'h0abcdef01)
        $display("test ram done");
    endtask
    // fill to full, refused write, drain in order, refused read
    task automatic t_fifo;
        @(negedge clk);
        {pipe, fmode, clr} = 3'b011;
        @(negedge clk);
        clr = 1'b0;
        for (int i = 0; i < DEPTH; i++)
            m.wr(36'(i * 7 + 1), 1'b1, 7'h00);
        `DCF_CHK({full, atop}, 2'b11)
        m.wr(36'h0deadbeef, 1'b1, 7'h00);
        // empty lags writes, so this first read only refreshes it
        m.rd(7'h00, q);
        `DCF_CHK({empty, adrn}, 2'b00)
        for (int i = 0; i < DEPTH; i++)
        begin
            m.rd(7'h00, q);
            `DCF_CHK(q, 36'(i * 7 + 1))
        end
        m.rd(7'h00, q);
        `DCF_CHK({empty, q}, {1'b1, 36'((DEPTH - 1) * 7 + 1)})
        $display("test fifo done");
    endtask
    // cut a hang short well past the expected run length
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        print_verdict;
    end
    initial
    begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_ram;
        t_fifo;
        print_verdict;
    end
endmodule
